// [logic/rstc_cfg.svh]
// Purpose: constants for the reset state controller
// Assumes: 8-bit ports and registers, 16-bit code addresses
// Notes: included by the package and by the top module
`ifndef RSTC_CFG_SVH
`define RSTC_CFG_SVH
`define RSTC_PORT_RST 8'hff
`define RSTC_PC_RST 16'h0000
`define RSTC_SP_RST 8'h07
`define RSTC_WDT_DIV 4'hc
`define RSTC_POR_BIT 1
`define RSTC_CLK_INT 1'b0
`define RSTC_DIV_RST 4'h0
`define RSTC_CAUSE_RST 8'h00
`endif

// [logic/rstc_pkg.sv]
// Purpose: types for the reset state controller
// Assumes: rstc_cfg.svh supplies the numbers
// Notes: none
`include "rstc_cfg.svh"
package rstc_pkg;
    typedef enum logic [1:0] {
        RSTC_ST_HOLD = 2'b00,
        RSTC_ST_RUN = 2'b01
    } rstc_state_t;
    typedef logic [7:0] rstc_byte_t;
endpackage

// [logic/rstc_sync_if.sv]
// Purpose: carries the combined reset between the two modules
// Assumes: one clock
// Notes: none
`timescale 1ns/1ps
interface rstc_sync_if;
    logic req_n;
    logic sys_rst_n;
    modport ctl (output req_n, input sys_rst_n);
    modport syn (input req_n, output sys_rst_n);
endinterface

// [logic/rstc_sync.sv]
// Purpose: reset synchronizer for the combined reset, async assert and sync release
// Assumes: req_n is low while any source requests reset
// Notes: two-stage release chain
`timescale 1ns/1ps
module rstc_sync (
    // clock
    input wire logic ref_clk,
    // link
    rstc_sync_if.syn sif
);
    logic [1:0] chain_r;
    // -----------------------------
    // release chain
    // -----------------------------
    always_ff @(posedge ref_clk or negedge sif.req_n) begin
        if (!sif.req_n) begin
            chain_r <= 2'b00;
        end else begin
            chain_r <= {chain_r[0], 1'b1};
        end
    end
    assign sif.sys_rst_n = chain_r[1];
endmodule

// [logic/rstc_top.sv]
// Purpose: reset state controller for a small microcontroller
// Assumes: monitors give level requests, active while supply is bad
// Notes: RAM is outside and has no reset input;
//   the pin is sensed on the clock and ignored while we drive it;
//   start values sit in registers that every reset loads
//
// Behaviour
// - reset halts core, fixes pins, disables timers
// - registers take reset values, stack pointer too
// - data memory untouched by reset
// - port latches all ones, open-drain
// - weak pull-ups on during and after reset
// - supply or power-on reset drives pin low
// - leave reset: pc cleared, internal oscillator
// - watchdog on, clocked sysclk over twelve
// - first fetch from code address zero
// - power-on exit sets cause flag bit one
// - enabled and selected supply monitor drop holds reset
`timescale 1ns/1ps
`include "rstc_cfg.svh"
module rstc_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // reset requests
    input wire logic por_req,
    input wire logic vdd_low,
    input wire logic vdd_mon_en,
    input wire logic vdd_mon_sel,
    input wire logic other_req,
    // external reset pin, open drain
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe,
    // core control
    output logic core_halt,
    output logic core_rst_n,
    output logic [15:0] fetch_addr,
    output logic irq_timer_en,
    output logic clk_sel_ext,
    output rstc_pkg::rstc_byte_t sp_init,
    // port control
    output rstc_pkg::rstc_byte_t port_latch,
    output logic port_push_pull,
    output logic weak_pullup_en,
    // watchdog
    output logic wdt_en,
    output logic wdt_tick,
    // cause
    output rstc_pkg::rstc_byte_t reset_cause_register
);
    import rstc_pkg::*;
    // -----------------------------
    // local signals
    // -----------------------------
    // combined reset carried to the release chain
    rstc_sync_if sif ();
    // request side
    logic supply_req;
    logic pin_drive;
    logic leaving;
    // state and cause
    rstc_state_t state_r, state_nxt;
    rstc_byte_t cause_r, cause_nxt;
    // watchdog divider
    logic [3:0] div_r, div_nxt;
    // raw domain memory
    logic por_seen_r, por_seen_nxt;
    logic pin_req_r, pin_req_nxt;
    // start values
    logic [15:0] pc_r, pc_nxt;
    rstc_byte_t sp_r, sp_nxt;
    rstc_byte_t latch_r, latch_nxt;
    logic clk_ext_r, clk_ext_nxt;
    // -----------------------------
    // request combining
    // -----------------------------
    // supply monitor counts only when enabled and selected
    assign supply_req = vdd_low & vdd_mon_en & vdd_mon_sel;
    // any request but the pin pulls the combined reset low at once; the pin one edge later
    assign sif.req_n = rst_n & ~por_req & ~supply_req & ~other_req
        & ~pin_req_r;
    // release chain: async assert, two-edge sync release
    rstc_sync u_sync (
        .ref_clk(ref_clk),
        .sif(sif)
    );
    // exit edge: still holding, release chain already high
    assign leaving = (state_r == RSTC_ST_HOLD) & sif.sys_rst_n;
    // -----------------------------
    // external reset pin
    // -----------------------------
    // low while a supply request lasts, and for power-on causes until the exit edge
    assign pin_drive = por_req | supply_req
        | (por_seen_r & (state_r == RSTC_ST_HOLD));
    // open drain: level fixed low, only the enable moves
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe = pin_drive;
    // -----------------------------
    // raw domain
    // -----------------------------
    // pin sensed on the clock and only while released, so our own
    // drive and its release glitch never latch a reset
    always_comb begin
        por_seen_nxt = por_seen_r | por_req;
        pin_req_nxt = ~rst_pin_in & ~pin_drive;
        // flag handed over on the exit edge, then forgotten
        if (leaving) begin
            por_seen_nxt = 1'b0;
        end
    end
    // loaded only by the master reset: power-on flag set, pin request clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            por_seen_r <= 1'b1;
            pin_req_r <= 1'b0;
        end else begin
            por_seen_r <= por_seen_nxt;
            pin_req_r <= pin_req_nxt;
        end
    end
    // -----------------------------
    // state
    // -----------------------------
    // hold until the chain releases, then run
    always_comb begin
        state_nxt = state_r;
        cause_nxt = cause_r;
        unique case (state_r)
            RSTC_ST_HOLD: begin
                state_nxt = RSTC_ST_RUN;
                // power-on or master reset marks the cause, other resets leave it clear
                cause_nxt = `RSTC_CAUSE_RST;
                cause_nxt[`RSTC_POR_BIT] = por_seen_r;
            end
            RSTC_ST_RUN: begin
                // only the async reset leaves this state
                state_nxt = RSTC_ST_RUN;
            end
            default: begin
                state_nxt = RSTC_ST_HOLD;
            end
        endcase
    end
    // reset values while the combined reset is low
    always_ff @(posedge ref_clk or negedge sif.sys_rst_n) begin
        if (!sif.sys_rst_n) begin
            state_r <= RSTC_ST_HOLD;
            cause_r <= `RSTC_CAUSE_RST;
        end else begin
            state_r <= state_nxt;
            cause_r <= cause_nxt;
        end
    end
    // -----------------------------
    // watchdog divider
    // -----------------------------
    // twelve-cycle count from the exit edge on
    always_comb begin
        div_nxt = `RSTC_DIV_RST;
        if (state_r == RSTC_ST_RUN && div_r != `RSTC_WDT_DIV - 4'h1) begin
            div_nxt = div_r + 4'h1;
        end
    end
    // divider idle while held
    always_ff @(posedge ref_clk or negedge sif.sys_rst_n) begin
        if (!sif.sys_rst_n) begin
            div_r <= `RSTC_DIV_RST;
        end else begin
            div_r <= div_nxt;
        end
    end
    // -----------------------------
    // start values
    // -----------------------------
    // no writer here, so each keeps its reset value
    always_comb begin
        pc_nxt = `RSTC_PC_RST;
        sp_nxt = `RSTC_SP_RST;
        latch_nxt = `RSTC_PORT_RST;
        clk_ext_nxt = `RSTC_CLK_INT;
    end
    // loaded by every reset, stack pointer included
    always_ff @(posedge ref_clk or negedge sif.sys_rst_n) begin
        if (!sif.sys_rst_n) begin
            pc_r <= `RSTC_PC_RST;
            sp_r <= `RSTC_SP_RST;
            latch_r <= `RSTC_PORT_RST;
            clk_ext_r <= `RSTC_CLK_INT;
        end else begin
            pc_r <= pc_nxt;
            sp_r <= sp_nxt;
            latch_r <= latch_nxt;
            clk_ext_r <= clk_ext_nxt;
        end
    end
    // -----------------------------
    // outputs
    // -----------------------------
    // core halted, timers off while held; memory has no tie here
    assign core_halt = (state_r == RSTC_ST_HOLD);
    assign core_rst_n = sif.sys_rst_n;
    assign irq_timer_en = (state_r == RSTC_ST_RUN);
    // start values from their registers
    assign fetch_addr = pc_r;
    assign clk_sel_ext = clk_ext_r;
    assign sp_init = sp_r;
    // ports: all ones, open drain, pull-ups always on
    assign port_latch = latch_r;
    assign port_push_pull = 1'b0;
    assign weak_pullup_en = 1'b1;
    // watchdog runs from the exit edge
    assign wdt_en = (state_r == RSTC_ST_RUN);
    assign wdt_tick = (state_r == RSTC_ST_RUN)
        && (div_r == `RSTC_WDT_DIV - 4'h1);
    // cause flag read by software
    assign reset_cause_register = cause_r;
endmodule

// [sim/rstc_pin_model.sv]
// Purpose: external reset pin with pull-up and push button
// Assumes: open drain pin, pulled up when released
// Notes: none
`timescale 1ns/1ps
module rstc_pin_model (
    // drive and button
    input wire logic oe,
    input wire logic drv,
    input wire logic press,
    output logic pin
);
    // pull-up unless device or button pulls low
    assign pin = !press && !(oe && !drv);
endmodule

// [sim/rstc_top_assertions.sv]
// Purpose: port checks for the reset state controller
// Assumes: one clock, async low reset
// Notes: bound to rstc_top
`timescale 1ns/1ps
module rstc_top_assertions (
    input wire logic ref_clk, rst_n, por_req, vdd_low, vdd_mon_en, vdd_mon_sel, other_req,
    input wire logic rst_pin_in, rst_pin_out, rst_pin_oe, core_halt, core_rst_n, irq_timer_en,
    input wire logic clk_sel_ext, port_push_pull, weak_pullup_en, wdt_en, wdt_tick,
    input wire logic [15:0] fetch_addr,
    input rstc_pkg::rstc_byte_t sp_init, port_latch, reset_cause_register
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_halt; !core_rst_n |-> core_halt && !wdt_en && !irq_timer_en; endproperty
    a_halt: assert property (p_halt) else $error("core runs in reset");
    property p_port; port_latch == 8'hff && !port_push_pull && weak_pullup_en; endproperty
    a_port: assert property (p_port) else $error("port state wrong");
    property p_regs; sp_init == 8'h07 && fetch_addr == 16'h0000 && !clk_sel_ext; endproperty
    a_regs: assert property (p_regs) else $error("start state wrong");
    property p_pin; por_req |-> rst_pin_oe && !rst_pin_out && !core_rst_n; endproperty
    a_pin: assert property (p_pin) else $error("pin not driven");
    property p_vdd; vdd_low && vdd_mon_en && vdd_mon_sel |-> !core_rst_n && rst_pin_oe; endproperty
    a_vdd: assert property (p_vdd) else $error("supply drop ignored");
    property p_rel; $rose(core_rst_n) |-> core_halt ##1 !core_halt && wdt_en; endproperty
    a_rel: assert property (p_rel) else $error("release order wrong");
    property p_async; other_req || (!rst_pin_in && !rst_pin_oe) |=> !core_rst_n; endproperty
    a_async: assert property (p_async) else $error("request not taken");
    property p_tick; wdt_tick ##1 wdt_en[*8] ##1 wdt_en[*3] |=> wdt_tick; endproperty
    a_tick: assert property (p_tick) else $error("watchdog period wrong");
    c_exit: cover property ($fell(core_halt));
    c_tick: cover property (wdt_tick);
    c_press: cover property (!rst_pin_in && !rst_pin_oe);
endmodule
bind rstc_top rstc_top_assertions u_chk (.*);

// [sim/testbench.sv]
// Purpose: self-checking bench for the reset state controller
// Assumes: exit three edges after requests drop, four after the button is released
// Notes: cause flag compared at each exit
`timescale 1ns/1ps
module testbench;
    import rstc_pkg::*;
    logic ref_clk = 0, rst_n = 0, por_req = 0, vdd_low = 0, vdd_mon_en = 0, vdd_mon_sel = 0;
    logic other_req = 0, press = 0, rst_pin_in, rst_pin_out, rst_pin_oe, core_halt, core_rst_n;
    logic irq_timer_en, clk_sel_ext, port_push_pull, weak_pullup_en, wdt_en, wdt_tick;
    logic [15:0] fetch_addr;
    rstc_byte_t sp_init, port_latch, reset_cause_register;
    rstc_byte_t exp_q[$];
    int num_errors = 0, compares = 0;
    always #20 ref_clk = ~ref_clk;
    rstc_top DUT (.*);
    rstc_pin_model u_pin (.oe(rst_pin_oe), .drv(rst_pin_out), .press(press), .pin(rst_pin_in));
    task automatic chk(string what, rstc_byte_t exp, rstc_byte_t got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // kind 0 power-on, 1 other, 2 button, 3 supply, 4 supply not selected, 5 master
    task automatic pulse(int kind);
        @(posedge ref_clk);
        rst_n <= kind != 5;
        por_req <= kind == 0;
        other_req <= kind == 1;
        press <= kind == 2;
        vdd_low <= kind == 3 || kind == 4;
        vdd_mon_en <= kind != 4 || $urandom_range(0, 1);
        vdd_mon_sel <= kind != 4;
        repeat ($urandom_range(2, 9)) @(posedge ref_clk);
        #1 chk("pin_oe", kind == 0 || kind == 3 || kind == 5, rst_pin_oe);
        if (kind == 4) chk("refused", 8'h01, core_rst_n);
        else exp_q.push_back(kind == 0 || kind == 5 ? 8'h02 : 8'h00);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        {por_req, other_req, press, vdd_low} <= 4'h0;
        repeat (30) @(posedge ref_clk);
        $display("test kind %0d done", kind);
    endtask
    // cause flag checked just after each exit
    always begin
        @(negedge core_halt);
        #1 chk("exits", 8'h01, exp_q.size() != 0);
        if (exp_q.size() != 0) begin
            chk("cause", exp_q.pop_front(), reset_cause_register & 8'h02);
        end
    end
    initial begin
        void'($urandom(89027));
        repeat (6) @(posedge ref_clk);
        exp_q.push_back(8'h02);
        rst_n <= 1;
        repeat (30) @(posedge ref_clk);
        $display("test power-on done");
        for (int i = 0; i < 12; i++) pulse(i < 6 ? i : $urandom_range(0, 5));
        final_report();
    end
    // hang guard
    initial begin
        #100us;
        num_errors++;
        final_report();
    end
endmodule
